//--- hdl/inms_core.sv
// Serial two-wire memory slave with an 8192 x 8 array, clocked by the bus clock.
// Assumes scl_in and sda_in come from the bus wires, and that the bench resolves
// the open-drain wire from sda_oe_out. The system clock only detects start and
// stop and reports status.
`timescale 1ns/1ns
`include "inms_params.svh"
module inms_core #(
  parameter logic [3:0] TYPE_CODE = `INMS_TYPE_CODE_DFLT // Arbitrary value.
) (
  input logic mclk_in,
  input logic reset_in,
  input logic scl_in,
  input logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input logic wp_in,
  input logic chip_select_strap_2_in,
  input logic chip_select_strap_1_in,
  input logic chip_select_strap_0_in,
  output inms_pkg::inms_status_s status_out
);
  import inms_pkg::*;

  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic [1:0] wr_sync_q;
  logic [1:0] blk_sync_q;
  logic wr_prev_q;
  logic blk_prev_q;
  logic link_rst_q;
  inms_status_s status_q;
  logic start_det;
  logic stop_det;
  logic scl_fall;

  inms_cfg_s cfg_s1_q;
  inms_cfg_s cfg_q;
  logic [`INMS_CNT_W-1:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic [7:0] rx_byte_q;
  inms_state_e state_q;
  logic ack_pend_q;
  logic set_addr_q;
  logic wr_pend_q;
  logic [`INMS_HI_USED_MSB:0] addr_hi_q;
  logic [7:0] rx_now;
  logic byte_done;
  logic ack_slot;
  logic match;

  logic sda_oe_q;
  logic sda_dat_q;
  logic [7:0] tx_q;
  logic [`INMS_ADDR_W-1:0] addr_q;
  logic [7:0] mem_q [0:`INMS_MEM_DEPTH-1];
  logic [7:0] mem_rd;
  logic load_rd;
  logic commit;
  logic wr_tog_q;
  logic blk_tog_q;

  // Compares the type and chip-select fields of an address word with this device.
  function automatic logic dev_match(
    input logic [7:0] b,
    input logic [2:0] cs
  );
    return (b[`INMS_TYPE_MSB:`INMS_TYPE_LSB] == TYPE_CODE)
      && (b[`INMS_CS_MSB:`INMS_CS_LSB] == cs);
  endfunction : dev_match

  // Two-flop synchronisers for the bus wires, plus one delayed copy for edges.
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      scl_sync_q <= `INMS_SYNC_IDLE;
      sda_sync_q <= `INMS_SYNC_IDLE;
      scl_prev_q <= `INMS_IDLE_LVL;
      sda_prev_q <= `INMS_IDLE_LVL;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  // Start is a falling data line and stop a rising one, both while the clock is high.
  assign start_det = scl_sync_q[1] && scl_prev_q && sda_prev_q && !sda_sync_q[1];
  assign stop_det = scl_sync_q[1] && scl_prev_q && !sda_prev_q && sda_sync_q[1];
  assign scl_fall = scl_prev_q && !scl_sync_q[1];

  // Holds the bus-clock logic in reset from any start or stop until the next clock fall.
  // The release lands while the bus clock is low, well clear of its next rise.
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      link_rst_q <= `INMS_IDLE_LVL;
    end
    else if (start_det || stop_det)
    begin
      link_rst_q <= `INMS_IDLE_LVL;
    end
    else if (scl_fall)
    begin
      link_rst_q <= '0;
    end
  end

  // Synchronises the write-event toggles coming from the bus clock.
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      wr_sync_q <= '0;
      blk_sync_q <= '0;
      wr_prev_q <= '0;
      blk_prev_q <= '0;
    end
    else
    begin
      wr_sync_q <= {wr_sync_q[0], wr_tog_q};
      blk_sync_q <= {blk_sync_q[0], blk_tog_q};
      wr_prev_q <= wr_sync_q[1];
      blk_prev_q <= blk_sync_q[1];
    end
  end

  // Status: busy between start and stop, one-cycle pulses per written or blocked byte.
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      status_q <= '0;
    end
    else
    begin
      if (start_det)
      begin
        status_q.bus_busy <= `INMS_IDLE_LVL;
      end
      else if (stop_det)
      begin
        status_q.bus_busy <= '0;
      end
      status_q.write_done <= wr_sync_q[1] ^ wr_prev_q;
      status_q.write_blocked <= blk_sync_q[1] ^ blk_prev_q;
    end
  end

  // Two-flop synchronisers for the straps; they are held steady for a whole frame.
  always_ff @(posedge scl_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cfg_s1_q <= '0;
      cfg_q <= '0;
    end
    else
    begin
      cfg_s1_q <= {wp_in, chip_select_strap_2_in, chip_select_strap_1_in,
        chip_select_strap_0_in};
      cfg_q <= cfg_s1_q;
    end
  end

  // Byte assembly terms; the data line is sampled on the rising clock edge.
  assign rx_now = {shift_q, sda_in};
  assign byte_done = (bit_cnt_q == `INMS_BIT_LAST);
  assign ack_slot = (bit_cnt_q == `INMS_BIT_ACK);
  assign match = dev_match(rx_now, cfg_q.cs);

  // Counts eight data clocks and the ninth acknowledge clock of every byte.
  always_ff @(posedge scl_in or posedge link_rst_q)
  begin
    if (link_rst_q)
    begin
      bit_cnt_q <= `INMS_BIT_FIRST;
    end
    else if (ack_slot)
    begin
      bit_cnt_q <= `INMS_BIT_FIRST;
    end
    else
    begin
      bit_cnt_q <= bit_cnt_q + `INMS_CNT_ONE;
    end
  end

  // Shifts in received bits, most significant first, and keeps each whole byte.
  always_ff @(posedge scl_in or posedge link_rst_q)
  begin
    if (link_rst_q)
    begin
      shift_q <= '0;
      rx_byte_q <= `INMS_BYTE_RST;
    end
    else
    begin
      shift_q <= rx_now[6:0];
      if (byte_done)
      begin
        rx_byte_q <= rx_now;
      end
    end
  end

  // Protocol phase; every frame starts at the address word after a start.
  always_ff @(posedge scl_in or posedge link_rst_q)
  begin
    if (link_rst_q)
    begin
      state_q <= INMS_ST_DEVADDR;
    end
    else if (byte_done)
    begin
      unique case (state_q)
        INMS_ST_DEVADDR:
        begin
          if (!match)
          begin
            state_q <= INMS_ST_IGNORE;
          end
          else if (rx_now[`INMS_RW_POS])
          begin
            state_q <= INMS_ST_RDATA;
          end
          else
          begin
            state_q <= INMS_ST_ADDR_HI;
          end
        end
        INMS_ST_ADDR_HI: state_q <= INMS_ST_ADDR_LO;
        INMS_ST_ADDR_LO: state_q <= INMS_ST_WDATA;
        INMS_ST_WDATA: state_q <= INMS_ST_WDATA;
        INMS_ST_RDATA: state_q <= INMS_ST_RDATA;
        INMS_ST_IGNORE: state_q <= INMS_ST_IGNORE;
        default: state_q <= INMS_ST_IGNORE;
      endcase
    end
    else if (ack_slot && (state_q == INMS_ST_RDATA) && sda_in)
    begin
      state_q <= INMS_ST_IGNORE;
    end
  end

  // Marks bytes to acknowledge, the address load and the pending array write.
  // The acknowledge never depends on write progress or on the protect input.
  always_ff @(posedge scl_in or posedge link_rst_q)
  begin
    if (link_rst_q)
    begin
      ack_pend_q <= '0;
      set_addr_q <= '0;
      wr_pend_q <= '0;
    end
    else if (byte_done)
    begin
      ack_pend_q <= ((state_q == INMS_ST_DEVADDR) && match)
        || (state_q == INMS_ST_ADDR_HI) || (state_q == INMS_ST_ADDR_LO)
        || (state_q == INMS_ST_WDATA);
      set_addr_q <= (state_q == INMS_ST_ADDR_LO);
      wr_pend_q <= (state_q == INMS_ST_WDATA);
    end
    else if (ack_slot)
    begin
      ack_pend_q <= '0;
      set_addr_q <= '0;
    end
    else if (bit_cnt_q == `INMS_BIT_FIRST)
    begin
      wr_pend_q <= '0;
    end
  end

  // Keeps the used part of the high address byte; its top three bits are dropped.
  always_ff @(posedge scl_in or posedge link_rst_q)
  begin
    if (link_rst_q)
    begin
      addr_hi_q <= '0;
    end
    else if (byte_done && (state_q == INMS_ST_ADDR_HI))
    begin
      addr_hi_q <= rx_now[`INMS_HI_USED_MSB:0];
    end
  end

  // Array access on the falling edge that ends an acknowledge clock.
  assign mem_rd = mem_q[addr_q];
  assign load_rd = (bit_cnt_q == `INMS_BIT_FIRST) && (state_q == INMS_ST_RDATA);
  assign commit = (bit_cnt_q == `INMS_BIT_FIRST) && wr_pend_q;

  // Drives the open-drain data line on falling edges: acknowledges and read data.
  always_ff @(negedge scl_in or posedge link_rst_q)
  begin
    if (link_rst_q)
    begin
      sda_oe_q <= '0;
      sda_dat_q <= `INMS_DRIVE_LVL;
      tx_q <= `INMS_BYTE_RST;
    end
    else
    begin
      sda_dat_q <= `INMS_DRIVE_LVL;
      if (ack_slot)
      begin
        sda_oe_q <= ack_pend_q;
      end
      else if (load_rd)
      begin
        sda_oe_q <= !mem_rd[7];
        tx_q <= {mem_rd[6:0], 1'b0};
      end
      else if (state_q == INMS_ST_RDATA)
      begin
        sda_oe_q <= !tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
      else
      begin
        sda_oe_q <= '0;
      end
    end
  end

  // Current word address; it survives starts and stops and wraps past the top.
  always_ff @(negedge scl_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      addr_q <= `INMS_ADDR_RST;
    end
    else if (ack_slot && set_addr_q)
    begin
      addr_q <= {addr_hi_q, rx_byte_q};
    end
    else if (commit || load_rd)
    begin
      addr_q <= inms_next_addr(addr_q);
    end
  end

  // Writes the array immediately when the byte's acknowledge ends, unless protected.
  always_ff @(negedge scl_in)
  begin
    if (commit && !cfg_q.wp)
    begin
      mem_q[addr_q] <= rx_byte_q;
    end
  end

  // Toggles one event line per written byte and one per blocked byte.
  always_ff @(negedge scl_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      wr_tog_q <= '0;
      blk_tog_q <= '0;
    end
    else if (commit)
    begin
      wr_tog_q <= wr_tog_q ^ !cfg_q.wp;
      blk_tog_q <= blk_tog_q ^ cfg_q.wp;
    end
  end

  assign sda_out = sda_dat_q;
  assign sda_oe_out = sda_oe_q;
  assign status_out = status_q;

endmodule : inms_core

//--- hdl/inms_params.svh
// Constants of the serial nonvolatile memory slave: widths, fields, counts, reset values.
// Assumes inclusion by the package and the core by bare name; it holds definitions only.
// Functional notes
// - First byte after start holds type, chip-select and direction fields.
// - Type or chip-select mismatch sends the device back to standby, silent.
// - Chip-select bits arrive strap 2 first and must equal all three straps.
// - Eighth address bit is direction: zero writes, one reads.
// - A matching address word is acknowledged low on the ninth clock.
// - Write transactions carry two address bytes, high first, each acknowledged.
// - Each written byte is acknowledged; master waits for that before continuing.
// - Reads shift eight bits out, release, then sample the master's acknowledge.
// - Writes finish at bus speed; no busy refusal, no post-stop wait.
// - Protect input high blocks all array writes; reads always allowed.
// - Further write bytes go to following addresses, wrapping to zero.
// - Each data byte lands in the array when its acknowledge completes.
// - A bare read returns the byte after the last one accessed.
// - The address counter resets to zero, so a bare read before any addressed access starts there.
// - Random read is an address phase, repeated start, then read word.
// - Acknowledged reads continue from incrementing addresses, wrapping to zero.
// - Data is sampled on rising clock edges, driven on falling edges.
// - A stop before a read acknowledge ends the read into standby.
`ifndef INMS_PARAMS_SVH
`define INMS_PARAMS_SVH
`define INMS_ADDR_W 13
`define INMS_MEM_DEPTH 8192
`define INMS_CNT_W 4
`define INMS_BIT_FIRST 4'h0
`define INMS_BIT_LAST 4'h7
`define INMS_BIT_ACK 4'h8
`define INMS_CNT_ONE 4'h1
`define INMS_ADDR_ONE 13'h0001
`define INMS_ADDR_RST 13'h0000
`define INMS_BYTE_RST 8'h00
`define INMS_TYPE_MSB 7
`define INMS_TYPE_LSB 4
`define INMS_CS_MSB 3
`define INMS_CS_LSB 1
`define INMS_RW_POS 0
`define INMS_HI_USED_MSB 4
`define INMS_TYPE_CODE_DFLT 4'h5
`define INMS_IDLE_LVL 1'b1
`define INMS_SYNC_IDLE 2'h3
`define INMS_DRIVE_LVL 1'b0
`endif

//--- hdl/inms_pkg.sv
// Types shared by the memory slave: protocol states, strap bundle, status bundle.
// Assumes the constants header is on the include path.
`include "inms_params.svh"
package inms_pkg;

  // Protocol phases, Gray coded along the usual write and read paths.
  typedef enum logic [2:0] {
    INMS_ST_DEVADDR = 3'h0,
    INMS_ST_ADDR_HI = 3'h1,
    INMS_ST_ADDR_LO = 3'h3,
    INMS_ST_WDATA = 3'h2,
    INMS_ST_RDATA = 3'h4,
    INMS_ST_IGNORE = 3'h5
  } inms_state_e;

  // Strapped configuration pins.
  typedef struct packed {
    logic wp;
    logic [2:0] cs;
  } inms_cfg_s;

  // Status seen on the system clock side.
  typedef struct packed {
    logic bus_busy;
    logic write_done;
    logic write_blocked;
  } inms_status_s;

  // Advances a word address; the carry out of the top bit is dropped so it wraps to zero.
  function automatic logic [`INMS_ADDR_W-1:0] inms_next_addr(
    input logic [`INMS_ADDR_W-1:0] a
  );
    return a + `INMS_ADDR_ONE;
  endfunction : inms_next_addr

endpackage : inms_pkg

//--- verif/inms_master.sv
// Bus master model: drives the bus clock and pulls the data wire low.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ns
module inms_master (
  output logic scl_out,
  output logic sda_low_out,
  input wire logic sda_in
);
  // The clock stands high and data is released between frames.
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // One bit: data changes mid-low and is sampled at the rising edge.
  task automatic bit_x(input logic b, output logic r);
    #31 sda_low_out = !b;
    #32 scl_out = 1'b1;
    r = sda_in;
    #62 scl_out = 1'b0;
  endtask : bit_x
  // Start, or repeated start when the clock is low.
  task automatic start_x();
    if (!scl_out)
    begin
      #31 sda_low_out = 1'b0;
      #32 scl_out = 1'b1;
    end
    #62 sda_low_out = 1'b1;
    #62 scl_out = 1'b0;
  endtask : start_x
  // Stop leaves the clock high.
  task automatic stop_x();
    #31 sda_low_out = 1'b1;
    #32 scl_out = 1'b1;
    #62 sda_low_out = 1'b0;
    #62;
  endtask : stop_x
  // Sends a byte most significant bit first and reads the acknowledge.
  task automatic send_x(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask : send_x
  // Receives a byte, then answers in the slot when one is wanted.
  task automatic recv_x(input logic nack, input logic slot, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
    if (slot) bit_x(nack, r);
  endtask : recv_x
endmodule : inms_master

//--- verif/inms_core_sva.sv
// Checker for the memory slave ports.
// Assumes it is bound to the core and sees its ports only.
`timescale 1ns/1ns
module inms_core_sva (
  input logic mclk_in,
  input logic reset_in,
  input logic scl_in,
  input logic sda_in,
  input logic sda_out,
  input logic sda_oe_out,
  input logic wp_in,
  input inms_pkg::inms_status_s status_out
);
  // Output timing on the bus wire and the status pulses.
  oe_rise_low_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    scl_in && $past(scl_in) |-> !$rose(sda_oe_out)) else $error("Drive rose while clock high");
  oe_fall_low_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    scl_in && $past(scl_in) |-> !$fell(sda_oe_out)) else $error("Drive fell while clock high");
  drive_low_a: assert property (@(posedge scl_in) disable iff (reset_in)
    sda_oe_out |-> !sda_out && !sda_in) else $error("Driven wire not low");
  done_pulse_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    $rose(status_out.write_done) |=> !status_out.write_done) else $error("Done pulse too long");
  blk_pulse_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    $rose(status_out.write_blocked) |=> !status_out.write_blocked) else $error("Blocked too long");
  done_wp_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    status_out.write_done |-> !wp_in && status_out.bus_busy) else $error("Write while protected");
  blk_wp_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    status_out.write_blocked |-> wp_in && status_out.bus_busy) else $error("Blocked unprotected");
  busy_start_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    $fell(sda_in) && scl_in && $past(scl_in) |-> ##[1:6] status_out.bus_busy)
    else $error("Start not seen");
  busy_stop_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    $rose(sda_in) && scl_in && $past(scl_in) |-> ##[1:6] !status_out.bus_busy)
    else $error("Stop not seen");
endmodule : inms_core_sva
bind inms_core inms_core_sva inms_core_sva_i (.mclk_in, .reset_in, .scl_in, .sda_in,
  .sda_out, .sda_oe_out, .wp_in, .status_out);

//--- verif/inms_core_tb.sv
// Testbench for the memory slave, driven through the bus master model.
// Assumes the core, its package and the master model are compiled first.
`timescale 1ns/1ns
module inms_core_tb;
  import inms_pkg::*;
  localparam logic [3:0] TCODE = 4'h5; // Arbitrary value.
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  inms_cfg_s cfg = '{wp: 1'b0, cs: 3'h5};
  logic scl, m_low, sda_oe, sda_o, ack;
  logic [7:0] rb;
  wire logic sda_w;
  inms_status_s status;
  int miscompares = 0;
  int comparisons = 0;
  int n_done = 0;
  int n_blk = 0;
  always #4 mclk_in = ~mclk_in;
  // Open-drain wire with a pull-up.
  assign sda_w = !(m_low || (sda_oe && !sda_o));
  inms_core #(.TYPE_CODE(TCODE)) inms_core_i (.mclk_in(mclk_in), .reset_in(reset_in),
    .scl_in(scl), .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe), .wp_in(cfg.wp),
    .chip_select_strap_2_in(cfg.cs[2]), .chip_select_strap_1_in(cfg.cs[1]),
    .chip_select_strap_0_in(cfg.cs[0]), .status_out(status));
  inms_master inms_master_i (.scl_out(scl), .sda_low_out(m_low), .sda_in(sda_w));
  // Counts the status pulses.
  always @(posedge mclk_in)
  begin
    if (status.write_done === 1'b1) n_done <= n_done + 1;
    if (status.write_blocked === 1'b1) n_blk <= n_blk + 1;
  end
  task automatic chk_ack(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: bit got %b exp %b", $time, got, exp);
    end
  endtask : chk_ack
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: byte got %h exp %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_cnt(input int got, input int exp);
    comparisons++;
    if (got != exp)
    begin
      miscompares++;
      $display("Error at %0t: count got %0d exp %0d", $time, got, exp);
    end
  endtask : chk_cnt
  task automatic tx(input logic [7:0] b, input logic exp);
    inms_master_i.send_x(b, ack);
    chk_ack(ack, exp);
  endtask : tx
  task automatic rx(input logic nack, input logic [7:0] exp);
    inms_master_i.recv_x(nack, 1'b1, rb);
    chk_byte(rb, exp);
  endtask : rx
  // Start, write word, then both address bytes with the top bits zero.
  task automatic addr(input logic [12:0] a);
    inms_master_i.start_x();
    tx({TCODE, cfg.cs, 1'b0}, 1'b1);
    tx({3'h0, a[12:8]}, 1'b1);
    tx(a[7:0], 1'b1);
  endtask : addr
  // Repeated start and read word after an address phase.
  task automatic rd_word();
    inms_master_i.start_x();
    tx({TCODE, cfg.cs, 1'b1}, 1'b1);
  endtask : rd_word
  task automatic finish_test();
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // Cuts a hang short.
  initial
  begin
    #400000;
    miscompares++;
    finish_test();
  end
  initial
  begin
    repeat (5) @(posedge mclk_in);
    #1 reset_in = 1'b0;
    repeat (8) @(posedge mclk_in);
    #1;
    // Words that differ in type or strap bits get no acknowledge.
    for (int i = 0; i < 3; i++)
    begin
      inms_master_i.start_x();
      tx({TCODE ^ 4'(i + 1), cfg.cs, 1'b0}, 1'b0);
      inms_master_i.stop_x();
      inms_master_i.start_x();
      tx({TCODE, cfg.cs ^ (3'h1 << i), 1'(i)}, 1'b0);
      inms_master_i.stop_x();
    end
    // Four bytes from near the top wrap to zero; the first three are read back with no wait.
    addr(13'h1FFE);
    for (int i = 0; i < 4; i++) tx(8'hA0 + 8'(i), 1'b1);
    inms_master_i.stop_x();
    addr(13'h1FFE);
    rd_word();
    for (int i = 0; i < 3; i++) rx(i == 2, 8'hA0 + 8'(i));
    inms_master_i.stop_x();
    // Bare read continues after the last byte, cut by a stop before the slot.
    inms_master_i.start_x();
    tx({TCODE, cfg.cs, 1'b1}, 1'b1);
    chk_ack(status.bus_busy, 1'b1);
    inms_master_i.recv_x(1'b0, 1'b0, rb);
    chk_byte(rb, 8'hA3);
    inms_master_i.stop_x();
    chk_ack(sda_oe, 1'b0);
    chk_ack(status.bus_busy, 1'b0);
    // Protected write is acknowledged but leaves the array alone.
    addr(13'h0010);
    tx(8'h33, 1'b1);
    inms_master_i.stop_x();
    @(posedge mclk_in);
    #1 cfg.wp = 1'b1;
    addr(13'h0010);
    tx(8'h55, 1'b1);
    inms_master_i.stop_x();
    addr(13'h0010);
    rd_word();
    rx(1'b1, 8'h33);
    inms_master_i.stop_x();
    repeat (10) @(posedge mclk_in);
    chk_cnt(n_done, 5);
    chk_cnt(n_blk, 1);
    finish_test();
  end
endmodule : inms_core_tb
